// ---- rtl/ccc_checksum_command.sv ----
// checksum command handler: mailbox request, memory walk, mailbox response
// assumes mailbox and memory ports driven by logic on i_clock;
// only i_resetn comes from outside and is synchronised here
`timescale 1ns/100ps
`include "ccc_regs.svh"

module ccc_checksum_command
    import ccc_pkg::*;
(
    input  wire logic        i_clock,        // 200 MHz clock
    input  wire logic        i_resetn,       // async reset, active low
    input  wire logic        i_mbox_wr,      // mailbox write strobe
    input  wire logic [4:0]  i_mbox_addr,    // mailbox write index
    input  wire logic [7:0]  i_mbox_wdata,   // mailbox write data
    input  wire logic [4:0]  i_mbox_rd_addr, // mailbox read index
    input  wire logic        i_cmd_go,       // packet complete, start pulse
    input  wire logic        i_security_en,  // device security enabled
    input  wire logic [7:0]  i_mem_data,     // byte at o_mem_addr
    input  wire logic        i_mem_valid,    // i_mem_data is valid
    output logic      [7:0]  o_mbox_rdata,   // mailbox read data, one cycle late
    output logic             o_busy,         // checksum running
    output logic             o_done,         // one-cycle completion pulse
    output logic             o_mem_req,      // memory read request
    output logic      [23:0] o_mem_addr      // memory byte address
);
    // reset release through two flops
    logic       rst_meta_r;
    logic       rst_n_r;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // state
    ccc_state_type state_r;
    ccc_state_type state_nxt;
    ccc_byte_type  mbox_r [`CCC_MB_COUNT];
    logic [7:0]    status_r;
    logic [7:0]    status_nxt;
    logic [15:0]   crc_r;
    logic [15:0]   crc_nxt;
    logic [15:0]   crc_step;
    logic [23:0]   addr_r;
    logic [23:0]   addr_nxt;
    logic [23:0]   end_addr_r;
    logic [23:0]   end_addr_nxt;
    logic          resp_r;
    logic          resp_nxt;
    logic          done_nxt;
    logic [7:0]    rdata_nxt;

    // request field decode
    wire        idle       = (state_r == CCC_IDLE);
    wire        wr_ok      = i_mbox_wr && idle && (i_mbox_addr <= `CCC_MB_LAST);
    wire        go         = i_cmd_go && idle;
    wire [4:0]  cmd_code   = mbox_r[`CCC_MB_CMD][`CCC_CMD_CODE_MSB:`CCC_CMD_CODE_LSB];
    wire [2:0]  mem_sel    = mbox_r[`CCC_MB_PARAM][`CCC_MEM_MSB:`CCC_MEM_LSB];
    wire [15:0] seed       = {mbox_r[`CCC_MB_SEED_HI], mbox_r[`CCC_MB_SEED_LO]};
    wire [15:0] start_off  = {mbox_r[`CCC_MB_START_HI], mbox_r[`CCC_MB_START_LO]};
    wire [15:0] end_off    = {mbox_r[`CCC_MB_END_HI], mbox_r[`CCC_MB_END_LO]};

    // memory space to base address
    wire        sel_flo    = (mem_sel == `CCC_MEM_FLASH_LO);
    wire        sel_rom    = (mem_sel == `CCC_MEM_ROM);
    wire        sel_ram    = (mem_sel == `CCC_MEM_RAM);
    wire        sel_fhi    = (mem_sel == `CCC_MEM_FLASH_HI);
    wire        mem_ok     = sel_flo | sel_rom | sel_ram | sel_fhi;
    wire [23:0] base       = sel_rom ? `CCC_BASE_ROM :
                             sel_ram ? `CCC_BASE_RAM :
                             sel_fhi ? `CCC_BASE_FLASH_HI : `CCC_BASE_FLASH_LO;
    wire [23:0] first_addr = base + {8'h00, start_off};
    wire [23:0] last_addr  = base + {8'h00, end_off};

    // span check: end below start or fewer than four bytes
    wire [16:0] span       = {1'b0, end_off} - {1'b0, start_off};
    wire        range_bad  = span[16] || (span[15:0] < `CCC_MIN_SPAN_M1);

    // abort cause, security first
    wire [2:0]  go_err     = i_security_en             ? `CCC_ERR_SECURITY :
                             (cmd_code != `CCC_CMD_CHECKSUM) ? `CCC_ERR_COMMAND :
                             !mem_ok                   ? `CCC_ERR_PARAM :
                             range_bad                 ? `CCC_ERR_RANGE :
                                                         `CCC_ERR_NONE;

    // one byte of the checksum
    ccc_crc_step #(
        .POLY (`CCC_CRC_POLY)
    ) u_step (
        .i_crc  (crc_r),
        .i_data (i_mem_data),
        .o_crc  (crc_step)
    );

    wire        take_byte  = (state_r == CCC_RUN) && i_mem_valid;
    wire        last_byte  = take_byte && (addr_r == end_addr_r);

    // sequencer
    always_comb begin
        state_nxt    = state_r;
        status_nxt   = status_r;
        crc_nxt      = crc_r;
        addr_nxt     = addr_r;
        end_addr_nxt = end_addr_r;
        resp_nxt     = resp_r;
        done_nxt     = 1'b0;
        unique case (state_r)
            CCC_IDLE: begin
                if (wr_ok && (i_mbox_addr[2:0] == `CCC_MB_CMD)) begin
                    resp_nxt = 1'b0;                      // new packet hides old answer
                end
                if (go) begin
                    resp_nxt = 1'b1;
                    if (go_err != `CCC_ERR_NONE) begin
                        status_nxt = {1'b1, go_err, `CCC_STAT_LOW};
                        done_nxt   = 1'b1;
                    end else begin
                        status_nxt   = `CCC_STAT_IDLE;
                        crc_nxt      = seed;
                        addr_nxt     = first_addr;
                        end_addr_nxt = last_addr;
                        state_nxt    = CCC_RUN;
                    end
                end
            end
            CCC_RUN: begin
                if (take_byte) begin
                    crc_nxt  = crc_step;
                    addr_nxt = addr_r + 24'h000001;
                end
                if (last_byte) begin
                    status_nxt = `CCC_STAT_OK;
                    done_nxt   = 1'b1;
                    state_nxt  = CCC_IDLE;
                end
            end
        endcase
    end

    // response view of the mailboxes
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_mbox_rd_addr <= `CCC_MB_LAST) begin
            rdata_nxt = mbox_r[i_mbox_rd_addr[2:0]];
        end
        if (resp_r) begin
            unique case (i_mbox_rd_addr)
                `CCC_RSP_STATUS: rdata_nxt = status_r;
                `CCC_RSP_SIG_HI: rdata_nxt = crc_r[15:8];
                `CCC_RSP_SIG_LO: rdata_nxt = crc_r[7:0];
                default: rdata_nxt = rdata_nxt;
            endcase
        end
    end

    // request mailboxes, written only while idle
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (int i = 0; i < `CCC_MB_COUNT; i++) begin
                mbox_r[i] <= 8'h00;
            end
        end else if (wr_ok) begin
            mbox_r[i_mbox_addr[2:0]] <= i_mbox_wdata;
        end
    end

    // sequencer and output registers
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r      <= CCC_IDLE;
            status_r     <= `CCC_STAT_IDLE;
            crc_r        <= 16'h0000;
            addr_r       <= 24'h000000;
            end_addr_r   <= 24'h000000;
            resp_r       <= 1'b0;
            o_done       <= 1'b0;
            o_busy       <= 1'b0;
            o_mem_req    <= 1'b0;
            o_mem_addr   <= 24'h000000;
            o_mbox_rdata <= 8'h00;
        end else begin
            state_r      <= state_nxt;
            status_r     <= status_nxt;
            crc_r        <= crc_nxt;
            addr_r       <= addr_nxt;
            end_addr_r   <= end_addr_nxt;
            resp_r       <= resp_nxt;
            o_done       <= done_nxt;
            o_busy       <= (state_nxt == CCC_RUN);
            o_mem_req    <= (state_nxt == CCC_RUN);
            o_mem_addr   <= addr_nxt;
            o_mbox_rdata <= rdata_nxt;
        end
    end
endmodule : ccc_checksum_command

// ---- rtl/ccc_crc_step.sv ----
// one byte of a 16-bit crc, most significant bit first, no final inversion
// assumes a caller that registers the result
`timescale 1ns/100ps
`include "ccc_regs.svh"

module ccc_crc_step
    import ccc_pkg::*;
#(
    parameter logic [15:0] POLY = `CCC_CRC_POLY
) (
    input  wire logic [15:0] i_crc,    // running value
    input  wire logic [7:0]  i_data,   // byte to fold in
    output logic      [15:0] o_crc     // updated value
);
    // eight shift steps, data bit 7 first
    always_comb begin
        logic [15:0] c;
        c = i_crc ^ {i_data, 8'h00};
        for (int k = 0; k < 8; k++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
        end
        o_crc = c;
    end
endmodule : ccc_crc_step

// ---- rtl/ccc_pkg.sv ----
// types of the checksum command handler
// assumes the constants header sits beside it
package ccc_pkg;
    typedef enum logic {
        CCC_IDLE = 1'b0,
        CCC_RUN  = 1'b1
    } ccc_state_type;

    typedef logic [7:0] ccc_byte_type;
endpackage : ccc_pkg

// ---- rtl/ccc_regs.svh ----
// named constants of the checksum command handler: codes, layouts, bases
// assumes inclusion by bare name from the design modules
`ifndef CCC_REGS_SVH
`define CCC_REGS_SVH

// mailbox indices of the request
`define CCC_MB_CMD        3'h0
`define CCC_MB_PARAM      3'h1
`define CCC_MB_SEED_HI    3'h2
`define CCC_MB_SEED_LO    3'h3
`define CCC_MB_START_HI   3'h4
`define CCC_MB_START_LO   3'h5
`define CCC_MB_END_HI     3'h6
`define CCC_MB_END_LO     3'h7
`define CCC_MB_COUNT      8
`define CCC_MB_LAST       5'h07

// response mailbox indices on the five-bit read index
`define CCC_RSP_STATUS    5'h01
`define CCC_RSP_SIG_HI    5'h02
`define CCC_RSP_SIG_LO    5'h03

// command byte: five-bit code sits in bits 7:3, so code 0x04 reads as byte 0x20
`define CCC_CMD_CODE_MSB  7
`define CCC_CMD_CODE_LSB  3
`define CCC_CMD_CHECKSUM  5'h04

// parameter byte: memory-space field in bits 7:5
`define CCC_MEM_MSB       7
`define CCC_MEM_LSB       5
`define CCC_MEM_FLASH_LO  3'h0
`define CCC_MEM_ROM       3'h1
`define CCC_MEM_RAM       3'h2
`define CCC_MEM_FLASH_HI  3'h6

// base addresses of the memory spaces
`define CCC_BASE_FLASH_LO 24'h000000
`define CCC_BASE_ROM      24'h300000
`define CCC_BASE_RAM      24'h800000
`define CCC_BASE_FLASH_HI 24'h010000

// least span in bytes, given as end minus start
`define CCC_MIN_SPAN_M1   16'h0003

// status byte: completion flag bit 7, error code 6:4, low nibble zero
`define CCC_STAT_IDLE     8'h00
`define CCC_STAT_OK       8'h80
`define CCC_STAT_LOW      4'h0
`define CCC_ERR_NONE      3'h0
`define CCC_ERR_SECURITY  3'h1
`define CCC_ERR_RANGE     3'h2
`define CCC_ERR_PARAM     3'h3
`define CCC_ERR_COMMAND   3'h4

// signature polynomial
`define CCC_CRC_POLY      16'h1021

`endif

// ---- verification/ccc_checksum_command_chk.sv ----
// port checker of the checksum command handler
// assumes it is bound onto ccc_checksum_command
`timescale 1ns/100ps

module ccc_checksum_command_chk (
    input wire logic        i_clock,        // clock
    input wire logic        i_resetn,       // reset, active low
    input wire logic        i_cmd_go,       // start pulse
    input wire logic        i_security_en,  // security on
    input wire logic        i_mem_valid,    // memory byte valid
    input wire logic [4:0]  i_mbox_rd_addr, // read index
    input wire logic [7:0]  o_mbox_rdata,   // read data
    input wire logic        o_busy,         // running
    input wire logic        o_done,         // done pulse
    input wire logic        o_mem_req,      // memory request
    input wire logic [23:0] o_mem_addr      // memory address
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // start taken while the device is secured
    sequence s_sec_go;
        i_cmd_go && !o_busy && i_security_en;
    endsequence
    // abort finishes without a run
    sequence s_abort;
        o_done && !o_busy;
    endsequence

    a_req_busy: assert property (o_mem_req == o_busy)
        else $error("memory request differs from busy");
    a_sec_abort: assert property (s_sec_go |=> s_abort)
        else $error("secured start not aborted");
    a_fall_done: assert property ($fell(o_busy) |-> o_done)
        else $error("run ended without done");
    a_addr_step: assert property (o_busy && i_mem_valid |=>
        o_done || o_mem_addr == $past(o_mem_addr) + 24'h1)
        else $error("address did not step by one");
    a_addr_hold: assert property (o_busy && !i_mem_valid |=> o_busy && $stable(o_mem_addr))
        else $error("address moved without a byte");
    a_run_bound: assert property ($rose(o_busy) |-> ##[1:1000] o_done)
        else $error("run never completed");
    a_high_index: assert property (i_mbox_rd_addr[4:3] != 2'h0 |=> o_mbox_rdata == 8'h00)
        else $error("unused mailbox not zero");
    a_status_done: assert property (o_done && i_mbox_rd_addr == 5'h01 |=>
        o_mbox_rdata[7] && o_mbox_rdata[3:0] == 4'h0)
        else $error("status wrong at completion");
    a_status_run: assert property (o_busy && i_mbox_rd_addr == 5'h01 |=> o_mbox_rdata == 8'h00)
        else $error("status not clear while running");
endmodule : ccc_checksum_command_chk

bind ccc_checksum_command ccc_checksum_command_chk u_chk (.i_clock, .i_resetn, .i_cmd_go,
    .i_security_en, .i_mem_valid, .i_mbox_rd_addr, .o_mbox_rdata, .o_busy, .o_done,
    .o_mem_req, .o_mem_addr);

// ---- verification/ccc_mem_model.sv ----
// memory model answering the handler's byte requests
// assumes requests and addresses change on the rising edge
`timescale 1ns/100ps

module ccc_mem_model (
    input  wire logic        i_clock, // clock
    input  wire logic        i_req,   // request level
    input  wire logic [23:0] i_addr,  // byte address
    input  wire logic        i_stall, // answer every other cycle
    output logic             o_valid, // byte valid
    output logic      [7:0]  o_data   // byte
);
    logic tog_r = 1'b0;

    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
    end
    // answer off the falling edge; data flips each cycle when not valid
    always @(negedge i_clock) begin
        tog_r   <= ~tog_r;
        o_valid <= i_req && (!i_stall || tog_r);
        o_data  <= (i_req && (!i_stall || tog_r)) ? i_addr[7:0] ^ i_addr[15:8] ^ i_addr[23:16]
                                                  : ~o_data;
    end
endmodule : ccc_mem_model

// ---- verification/tb_top.sv ----
// self-checking bench of the checksum command handler
// assumes the memory model answers the handler's byte requests
`timescale 1ns/100ps

module tb_top;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, go = 1'b0, sec = 1'b0, stall = 1'b0;
    logic [4:0]  wa = 5'h00, ra = 5'h00;
    logic [7:0]  wd = 8'h00, rdata, mdata;
    logic        busy, done, mreq, mvalid;
    logic [23:0] maddr;
    int          num_errors = 0, n_compared = 0;

    always #2.5 clk = ~clk;

    ccc_checksum_command dut (.i_clock(clk), .i_resetn(rstn), .i_mbox_wr(wr), .i_mbox_addr(wa),
        .i_mbox_wdata(wd), .i_mbox_rd_addr(ra), .i_cmd_go(go), .i_security_en(sec),
        .i_mem_data(mdata), .i_mem_valid(mvalid), .o_mbox_rdata(rdata), .o_busy(busy),
        .o_done(done), .o_mem_req(mreq), .o_mem_addr(maddr));
    ccc_mem_model mem (.i_clock(clk), .i_req(mreq), .i_addr(maddr), .i_stall(stall),
        .o_valid(mvalid), .o_data(mdata));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [4:0] idx, output logic [7:0] val);
        @(negedge clk) ra = idx;
        @(negedge clk) val = rdata;
    endtask : rd

    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        return c;
    endfunction : crc

    // writes a request, starts it, polls status, checks the response
    task automatic run(input logic [7:0] cmd, par, input logic [15:0] seed, st, en,
                       input logic [7:0] stat);
        logic [7:0]  b [8];
        logic [7:0]  v;
        logic [15:0] sig;
        logic [23:0] base;
        int          n;
        b = '{cmd, par, seed[15:8], seed[7:0], st[15:8], st[7:0], en[15:8], en[7:0]};
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            wr = 1'b1;
            wa = 5'(i);
            wd = b[i];
        end
        @(negedge clk);
        wr = 1'b0;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        ra = 5'h01;
        chk(16'(busy), 16'(stat == 8'h80));
        chk(16'(done), 16'(stat != 8'h80));
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rdata[7] !== 1'b1 && n < 500);
        chk(16'(rdata), 16'(stat));
        chk(16'({busy, done}), 16'h0000);
        if (stat === 8'h80 && stall === 1'b0) chk(16'(n), en - st + 16'h0002);
        rd(5'h00, v);
        chk(16'(v), 16'(cmd));
        if (stat === 8'h80) begin
            case (par[7:5])
                3'h1: base = 24'h300000;
                3'h2: base = 24'h800000;
                3'h6: base = 24'h010000;
                default: base = 24'h000000;
            endcase
            sig = seed;
            for (int a = st; a <= en; a++) begin
                v = 8'(base + 24'(a));
                sig = crc(sig, v ^ 8'(base[15:8] + 8'(a >> 8)) ^ base[23:16]);
            end
            rd(5'h02, v);
            chk(16'(v), 16'(sig[15:8]));
            rd(5'h03, v);
            chk(16'(v), 16'(sig[7:0]));
        end
    endtask : run

    task automatic wrap_up();
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // watchdog cuts a hang short
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end

    // main sequence
    initial begin
        logic [2:0] ms [4];
        logic [2:0] rs [4];
        logic [7:0] v;
        ms = '{3'h0, 3'h2, 3'h6, 3'h1};
        rs = '{3'h3, 3'h4, 3'h5, 3'h7};
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        run(8'h20, 8'h20, 16'h1d0f, 16'h0010, 16'h0013, 8'h80);
        run(8'h20, 8'h20, 16'h1d0f, 16'h0010, 16'h0012, 8'ha0);
        run(8'h20, 8'h00, 16'h1d0f, 16'h0040, 16'h0010, 8'ha0);
        stall = 1'b1;
        foreach (ms[i]) run(8'h20, {ms[i], 5'h00}, 16'hbeef, 16'h00fe, 16'h0127, 8'h80);
        stall = 1'b0;
        foreach (rs[i]) run(8'h20, {rs[i], 5'h00}, 16'h1d0f, 16'h0000, 16'h0010, 8'hb0);
        sec = 1'b1;
        run(8'h20, 8'h20, 16'h1d0f, 16'h0000, 16'h0010, 8'h90);
        sec = 1'b0;
        run(8'h28, 8'h20, 16'h1d0f, 16'h0000, 16'h0010, 8'hc0);
        rd(5'h09, v);
        chk(16'(v), 16'h0000);
        wrap_up();
    end
endmodule : tb_top
